// >>> inc/ascs_regs.vh
// Register map and field constants for the scan sequencer control block
`ifndef ASCS_REGS_VH
`define ASCS_REGS_VH

// Word byte addresses on the register bus
`define ASCS_ADR_CTL 8'h00
`define ASCS_ADR_TRG 8'h04
`define ASCS_ADR_CFG 8'h08
`define ASCS_ADR_IFLG 8'h0C
`define ASCS_ADR_IEN 8'h10
`define ASCS_ADR_RES0 8'h20

// Scan control fields
`define ASCS_CTL_IDX_HI 14
`define ASCS_CTL_IDX_LO 12
`define ASCS_CTL_ACT 10
`define ASCS_CTL_TEN 4
`define ASCS_CTL_SSS 1
`define ASCS_CTL_MEN 0

// Trigger and input select fields
`define ASCS_TRG_LAST_HI 13
`define ASCS_TRG_LAST_LO 11
`define ASCS_TRG_FIRST_HI 10
`define ASCS_TRG_FIRST_LO 8
`define ASCS_TRG_JUST 7
`define ASCS_TRG_REP 6
`define ASCS_TRG_SRC_HI 5
`define ASCS_TRG_SRC_LO 4
`define ASCS_TRG_SMP_HI 2
`define ASCS_TRG_SMP_LO 0

// Trigger source codes
`define ASCS_SRC_SOFT 2'h0
`define ASCS_SRC_TIMER 2'h1
`define ASCS_SRC_PIN 2'h3

// Reset values and sample time base
`define ASCS_SMP_RST 3'h5
`define ASCS_RANGE_RST 3'h4
`define ASCS_SMP_BASE 4'h4

// Write of 0 to the start bit is ignored for this many timer ticks after a 1
`define ASCS_STOP_HOLD 2'h2

`endif

// >>> hdl/ascs_top.v
// Scan sequencer control for an eight-input successive-scan converter
// Overview of operation
// - Loading a result for input m sets its completion flag.
// - Loading a result while completion flag set sets the overwrite flag.
// - Flags read 1 on cause; write 1 clears, write 0 does nothing.
// - Conversion continues after overwrite; reading results does not matter.
// - Interrupt request only while an enabled flag is set.
// - Control bits 14-12 show the input currently being converted.
// - After stop, index holds last input, or zero after highest input.
// - Control bit 10 reads 1 while a scan executes.
// - Trigger accept enable at bit 4 gates every trigger source.
// - Writing 1 to bit 1 triggers with software source; 0 stops after current conversion.
// - Start/stop bit reads 1 during conversion, clears itself at end.
// - Write of 0 may be ignored two timer ticks after writing 1.
// - Module enable gates the clock; software reads 1 until clock off.
// - Justify bit 7 realigns all result views without changing values.
// - Trigger-select bit 6 chooses continuous or single scan.
// - Source 3 is pin, 1 is timer underflow, 0 is software.
// - Sample time is field value plus four ticks; resets to 5.
// - Supply range field resets to 4; codes 5 to 7 reserved.
// - Flag and enable registers: overwrite bits 15-8, completion bits 7-0.
// - Each input has a read-only 16-bit result, reset zero.
// - Triggers accepted only when idle, started on a timer tick.
// - Inputs converted from first to last in ascending order.
// - Continuous mode rescans until stop; single mode stops after pass.
// - With pin source enabled, falling pin edge starts conversion.
`default_nettype none
`include "ascs_regs.vh"

module ascs_top #(
  parameter NUM_IN = 8,
  parameter RES_W = 10,
  parameter CONV_TICKS = 11
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Trigger sources
  input wire timer_tick_i,
  input wire timer_underflow_i,
  input wire external_trigger_pin_i,
  // Conversion core
  output reg core_sample_o,
  output reg core_convert_o,
  output reg [2:0] core_input_o,
  output reg [2:0] core_range_o,
  output reg core_clk_en_o,
  input wire core_done_i,
  input wire [RES_W-1:0] core_result_i,
  // Interrupt request
  output reg irq_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONVERT = 2'h2;

  reg [2:0] idx_q;
  reg act_q;
  reg ten_q;
  reg sss_q;
  reg men_q;
  reg [2:0] last_q;
  reg [2:0] first_q;
  reg just_q;
  reg rep_q;
  reg [1:0] src_q;
  reg [2:0] smp_q;
  reg [2:0] range_q;
  reg [15:0] iflg_q;
  reg [15:0] ien_q;
  reg [RES_W-1:0] res_q [0:NUM_IN-1];
  reg [1:0] st_q;
  reg [3:0] cnt_q;
  reg stop_q;
  reg [1:0] hold_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_s3_q;
  reg pin_fall_q;
  reg soft_trig_q;

  // Left or right view of a stored result
  function [15:0] res_view;
    input [RES_W-1:0] val;
    input left;
    begin
      if (left) begin
        res_view = {val, {(16 - RES_W){1'b0}}};
      end else begin
        res_view = {{(16 - RES_W){1'b0}}, val};
      end
    end
  endfunction

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lo = wb_req & wb_we_i & wb_sel_i[0];
  wire wr_hi = wb_req & wb_we_i & wb_sel_i[1];
  wire ctl_wr = wb_adr_i == `ASCS_ADR_CTL;

  // Sync pin into clock domain
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
      pin_fall_q <= 1'b0;
    end else begin
      pin_s1_q <= external_trigger_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s3_q & ~pin_s2_q) begin
        pin_fall_q <= 1'b1;
      end else if (timer_tick_i) begin
        pin_fall_q <= 1'b0;
      end
    end
  end

  reg trig_raw;
  always @* begin
    case (src_q)
      `ASCS_SRC_SOFT: trig_raw = soft_trig_q;
      `ASCS_SRC_TIMER: trig_raw = timer_underflow_i;
      `ASCS_SRC_PIN: trig_raw = pin_fall_q;
      default: trig_raw = 1'b0;
    endcase
  end

  wire start = men_q & ten_q & ~act_q & trig_raw & timer_tick_i;
  wire done = (st_q == ST_CONVERT) & core_done_i;
  wire at_last = idx_q == last_q;

  // Per-input load, flag set events
  reg [NUM_IN-1:0] load_v;
  integer k;
  always @* begin
    for (k = 0; k < NUM_IN; k = k + 1) begin
      load_v[k] = done & (idx_q == k[2:0]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : g_in
      always @(posedge clk_i) begin
        if (rst_i) begin
          res_q[g] <= {RES_W{1'b0}};
        end else if (load_v[g]) begin
          res_q[g] <= core_result_i;
        end
      end
      always @(posedge clk_i) begin
        if (rst_i) begin
          iflg_q[g] <= 1'b0;
          iflg_q[g + 8] <= 1'b0;
        end else begin
          if (load_v[g]) begin
            iflg_q[g] <= 1'b1;
          end else if (wr_lo && wb_adr_i == `ASCS_ADR_IFLG && wb_dat_i[g]) begin
            iflg_q[g] <= 1'b0;
          end
          if (load_v[g] & iflg_q[g]) begin
            iflg_q[g + 8] <= 1'b1;
          end else if (wr_hi && wb_adr_i == `ASCS_ADR_IFLG && wb_dat_i[g + 8]) begin
            iflg_q[g + 8] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Register writes and scan sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      ten_q <= 1'b0;
      sss_q <= 1'b0;
      men_q <= 1'b0;
      last_q <= 3'h0;
      first_q <= 3'h0;
      just_q <= 1'b0;
      rep_q <= 1'b0;
      src_q <= 2'h0;
      smp_q <= `ASCS_SMP_RST;
      range_q <= `ASCS_RANGE_RST;
      ien_q <= 16'h0000;
      idx_q <= 3'h0;
      act_q <= 1'b0;
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      stop_q <= 1'b0;
      hold_q <= 2'h0;
      soft_trig_q <= 1'b0;
    end else begin
      if (timer_tick_i && hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
      if (start) begin
        soft_trig_q <= 1'b0;
      end
      if (wr_lo && ctl_wr) begin
        ten_q <= wb_dat_i[`ASCS_CTL_TEN];
        men_q <= wb_dat_i[`ASCS_CTL_MEN];
        if (wb_dat_i[`ASCS_CTL_SSS]) begin
          if (src_q == `ASCS_SRC_SOFT && !act_q && wb_dat_i[`ASCS_CTL_TEN]) begin
            soft_trig_q <= 1'b1;
            sss_q <= 1'b1;
          end
          hold_q <= `ASCS_STOP_HOLD;
        end else if (hold_q == 2'h0 && (act_q || soft_trig_q)) begin
          // ignore 0 briefly; stop after current
          stop_q <= act_q;
          soft_trig_q <= 1'b0;
          sss_q <= act_q;
        end
      end
      if (wr_lo && wb_adr_i == `ASCS_ADR_TRG) begin
        just_q <= wb_dat_i[`ASCS_TRG_JUST];
        rep_q <= wb_dat_i[`ASCS_TRG_REP];
        src_q <= wb_dat_i[`ASCS_TRG_SRC_HI:`ASCS_TRG_SRC_LO];
        smp_q <= wb_dat_i[`ASCS_TRG_SMP_HI:`ASCS_TRG_SMP_LO];
      end
      if (wr_hi && wb_adr_i == `ASCS_ADR_TRG) begin
        last_q <= wb_dat_i[`ASCS_TRG_LAST_HI:`ASCS_TRG_LAST_LO];
        first_q <= wb_dat_i[`ASCS_TRG_FIRST_HI:`ASCS_TRG_FIRST_LO];
      end
      if (wr_lo && wb_adr_i == `ASCS_ADR_CFG) begin
        range_q <= wb_dat_i[2:0];
      end
      if (wr_lo && wb_adr_i == `ASCS_ADR_IEN) begin
        ien_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_hi && wb_adr_i == `ASCS_ADR_IEN) begin
        ien_q[15:8] <= wb_dat_i[15:8];
      end
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            act_q <= 1'b1;
            sss_q <= 1'b1;
            stop_q <= 1'b0;
            idx_q <= first_q;
            cnt_q <= {1'b0, smp_q} + `ASCS_SMP_BASE;
            st_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (timer_tick_i) begin
            if (cnt_q <= 4'h1) begin
              cnt_q <= 4'h0;
              st_q <= ST_CONVERT;
            end else begin
              cnt_q <= cnt_q - 4'h1;
            end
          end
        end
        ST_CONVERT: begin
          if (core_done_i) begin
            if (stop_q || !men_q || (at_last && !rep_q)) begin
              act_q <= 1'b0;
              sss_q <= 1'b0;
              st_q <= ST_IDLE;
              if (idx_q == NUM_IN - 1) begin
                idx_q <= 3'h0;
              end
            end else begin
              idx_q <= at_last ? first_q : idx_q + 3'h1;
              cnt_q <= {1'b0, smp_q} + `ASCS_SMP_BASE;
              st_q <= ST_SAMPLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Core drive, interrupt and bus answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      core_sample_o <= 1'b0;
      core_convert_o <= 1'b0;
      core_input_o <= 3'h0;
      core_range_o <= `ASCS_RANGE_RST;
      core_clk_en_o <= 1'b0;
      irq_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      core_sample_o <= st_q == ST_SAMPLE;
      core_convert_o <= st_q == ST_CONVERT;
      core_input_o <= idx_q;
      core_range_o <= range_q;
      core_clk_en_o <= men_q | act_q;
      irq_o <= |(iflg_q & ien_q);
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `ASCS_ADR_CTL: wb_dat_o <= {17'h0_0000, idx_q, 1'b0, act_q, 5'h00, ten_q,
                                      2'h0, sss_q, men_q | act_q};
          `ASCS_ADR_TRG: wb_dat_o <= {18'h0_0000, last_q, first_q, just_q, rep_q,
                                      src_q, 1'b0, smp_q};
          `ASCS_ADR_CFG: wb_dat_o <= {29'h0000_0000, range_q};
          `ASCS_ADR_IFLG: wb_dat_o <= {16'h0000, iflg_q};
          `ASCS_ADR_IEN: wb_dat_o <= {16'h0000, ien_q};
          default: begin
            if (wb_adr_i[7:5] == 3'h1 && wb_adr_i[1:0] == 2'h0) begin
              wb_dat_o <= {16'h0000, res_view(res_q[wb_adr_i[4:2]], just_q)};
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> tb/ascs_core_model.sv
// Behavioural conversion core: odd inputs answer slowly
`default_nettype none
module ascs_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sequencer side
  input wire logic convert_i,
  input wire logic [2:0] input_i,
  output logic done_o,
  output logic [9:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // Result bus shows the inverse outside the done pulse
  assign result_o = done_o ? {input_i, 7'h15} : ~{input_i, 7'h15};
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || !convert_i || done_o) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == (input_i[0] ? 4'h6 : 4'h1)) begin
      done_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/ascs_asserts.sv
// Port checker for the scan sequencer control block
`default_nettype none
`include "ascs_regs.vh"
module ascs_sva (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Triggers, core, interrupt
  input wire logic timer_tick_i,
  input wire logic core_sample_o,
  input wire logic core_convert_o,
  input wire logic [2:0] core_input_o,
  input wire logic core_clk_en_o,
  input wire logic core_done_i,
  input wire logic irq_o
);
  logic [2:0] smp_q;
  logic [2:0] fst_q;
  logic ten_q;
  logic [3:0] tk_q;
  logic tk_d_q;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire cause = core_done_i || wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of sample time, first input and trigger enable
  always_ff @(posedge clk_i) begin
    tk_d_q <= timer_tick_i;
    tk_q <= core_sample_o ? tk_q + {3'h0, tk_d_q} : 4'h0;
    if (rst_i) begin
      smp_q <= `ASCS_SMP_RST;
      fst_q <= 3'h0;
      ten_q <= 1'b0;
    end else if (wr && wb_adr_i == `ASCS_ADR_TRG) begin
      smp_q <= wb_dat_i[2:0];
      fst_q <= wb_dat_i[10:8];
    end else if (wr && wb_adr_i == `ASCS_ADR_CTL) begin
      ten_q <= wb_dat_i[4];
    end
  end
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  a_smp_len: assert property (
    $fell(core_sample_o) |-> tk_q == {1'b0, smp_q} + `ASCS_SMP_BASE)
    else $error("bad sample time");
  a_start_tick: assert property (
    $rose(core_sample_o) && !$past(core_convert_o)
    |-> $past(timer_tick_i) || $past(timer_tick_i, 2)) else $error("start off tick");
  a_start_gate: assert property (
    $rose(core_sample_o) && !$past(core_convert_o) |-> ten_q) else $error("ungated start");
  a_next_input: assert property (
    $past(core_done_i, 2) && core_sample_o
    |-> core_input_o == fst_q || core_input_o == $past(core_input_o) + 3'h1)
    else $error("input order");
  a_clk_gate: assert property (
    !core_clk_en_o |-> !core_sample_o && !core_convert_o) else $error("core ran gated");
  a_irq_cause: assert property (
    $rose(irq_o) |-> $past(cause) || $past(cause, 2) || wb_ack_o) else $error("stray irq");
endmodule
bind ascs_top ascs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .timer_tick_i(timer_tick_i),
  .core_sample_o(core_sample_o), .core_convert_o(core_convert_o),
  .core_input_o(core_input_o), .core_clk_en_o(core_clk_en_o),
  .core_done_i(core_done_i), .irq_o(irq_o));
`default_nettype wire

// >>> tb/tb.sv
// Register-level bench for the scan sequencer control block
`default_nettype none
`include "ascs_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic tick = 1'b0, tuf = 1'b0, pin = 1'b1;
  logic [1:0] tdv = 2'h0;
  logic [7:0] adr = 8'h00;
  logic [15:0] dat = 16'h0000;
  logic [31:0] rdat;
  logic [9:0] res;
  logic [2:0] inp;
  logic [2:0] rng;
  logic [15:0] cq;
  logic ack, cnv, irq, done;
  int errors = 0, n_compared = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tdv <= tdv + 2'h1;
    tick <= tdv == 2'h3;
  end
  ascs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i({16'h0000, dat}),
    .wb_dat_o(rdat), .wb_ack_o(ack), .timer_tick_i(tick), .timer_underflow_i(tuf),
    .external_trigger_pin_i(pin), .core_sample_o(), .core_convert_o(cnv),
    .core_input_o(inp), .core_range_o(rng), .core_clk_en_o(), .core_done_i(done),
    .core_result_i(res), .irq_o(irq));
  ascs_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .convert_i(cnv),
    .input_i(inp), .done_o(done), .result_o(res));
  task automatic results;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      i++;
      if (i > 50) begin
        errors++;
        results();
      end
    end while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask
  // Poll the active bit until it reads v
  task automatic act(input logic v);
    logic [15:0] q;
    for (int i = 0; i < 300; i++) begin
      wb(1'b0, `ASCS_ADR_CTL, 16'h0000, q);
      if (q[10] === v) return;
    end
    errors++;
    results();
  endtask
  function automatic logic [15:0] rj(input logic [2:0] m);
    return {6'h00, m, 7'h15};
  endfunction
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`ASCS_ADR_TRG, 16'h0005);
    rc(`ASCS_ADR_CFG, 16'h0004);
    rc(`ASCS_ADR_RES0, 16'h0000);
    rc(8'hFC, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      wr(`ASCS_ADR_CFG, 16'hFFF8 | 16'(k));
      rc(`ASCS_ADR_CFG, 16'(k));
    end
    chk({13'h0000, rng}, 16'h0004);
    wr(`ASCS_ADR_CTL, 16'h0011);
    wr(`ASCS_ADR_TRG, 16'h1A00);
    for (int p = 0; p < 2; p++) begin
      wr(`ASCS_ADR_CTL, 16'h0013);
      act(1'b1);
      act(1'b0);
      rc(`ASCS_ADR_CTL, 16'h3011);
      rc(`ASCS_ADR_IFLG, p ? 16'h0C0C : 16'h000C);
    end
    rc(`ASCS_ADR_RES0 + 8'h08, rj(2));
    wr(`ASCS_ADR_IEN, 16'h0800);
    rc(`ASCS_ADR_IEN, 16'h0800);
    chk({15'h0000, irq}, 16'h0001);
    wr(`ASCS_ADR_IFLG, 16'h0804);
    rc(`ASCS_ADR_IFLG, 16'h0408);
    chk({15'h0000, irq}, 16'h0000);
    wr(`ASCS_ADR_TRG, 16'h1A80);
    rc(`ASCS_ADR_RES0 + 8'h0C, rj(3) << 6);
    wr(`ASCS_ADR_CTL, 16'h0003);
    repeat (40) @(posedge clk_i);
    rc(`ASCS_ADR_IFLG, 16'h0408);
    rc(`ASCS_ADR_CTL, 16'h3001);
    wr(`ASCS_ADR_CTL, 16'h0001);
    wr(`ASCS_ADR_TRG, 16'h3F33);
    wr(`ASCS_ADR_CTL, 16'h0011);
    pin <= 1'b0;
    act(1'b1);
    act(1'b0);
    pin <= 1'b1;
    rc(`ASCS_ADR_CTL, 16'h0011);
    rc(`ASCS_ADR_RES0 + 8'h1C, rj(7));
    wr(`ASCS_ADR_TRG, 16'h0010);
    tuf <= 1'b1;
    repeat (4) @(posedge clk_i);
    tuf <= 1'b0;
    act(1'b1);
    act(1'b0);
    rc(`ASCS_ADR_IFLG, 16'h0489);
    wr(`ASCS_ADR_TRG, 16'h0847);
    wr(`ASCS_ADR_CTL, 16'h0013);
    act(1'b1);
    repeat (400) @(posedge clk_i);
    wb(1'b0, `ASCS_ADR_CTL, 16'h0000, cq);
    chk(cq & 16'h6FFF, 16'h0413);
    wr(`ASCS_ADR_CTL, 16'h0011);
    act(1'b0);
    rc(`ASCS_ADR_IFLG, 16'h078B);
    results();
  end
endmodule
`default_nettype wire
